// ==== hw/uadc_top.v ====
// USB attach, detach, wake and suspend control with an Avalon-MM register slave.
`timescale 1ns/1ps
`include "uadc_defs.vh"
module uadc_top #(
  parameter NUM_PINS = 16,
  parameter SEL_W = 4
) (
  input wire mclk,
  input wire srst,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire [NUM_PINS-1:0] general_io_pin_in,
  output reg [NUM_PINS-1:0] general_io_pin_out,
  output reg [NUM_PINS-1:0] general_io_pin_oe,
  output reg dplus_line_oe,
  output reg dminus_line_oe,
  output reg dplus_pullup_int,
  output reg radio_enable,
  output reg load_enable,
  output reg remote_wake_send,
  output reg endpoint_audio
);
  // ===================================================================
  // Registers
  reg [6:0] ctrl;
  reg [31:0] pinsel;
  reg [15:0] max_power_setting;
  reg bus_busy;
  reg [NUM_PINS-1:0] raw_in;
  wire detach_sync;
  wire vbus_sync;
  wire [SEL_W-1:0] pullup_source_select;
  wire [SEL_W-1:0] vbus_pin_select;
  wire [SEL_W-1:0] detach_pin_select;
  wire [SEL_W-1:0] wake_pin_select;
  wire detached;
  wire vbus_ok;
  wire attach_ok;
  wire bus_powered;
  wire in_suspend;
  reg [31:0] next_readdata;

  assign pullup_source_select = pinsel[`UADC_PS_PULLUP_LSB +: SEL_W];
  assign vbus_pin_select = pinsel[`UADC_PS_VBUS_LSB +: SEL_W];
  assign detach_pin_select = pinsel[`UADC_PS_DETACH_LSB +: SEL_W];
  assign wake_pin_select = pinsel[`UADC_PS_WAKE_LSB +: SEL_W];

  // ===================================================================
  // Pin input selection
  always @(posedge mclk) begin
    if (srst) begin
      raw_in <= {NUM_PINS{1'b0}};
    end else begin
      raw_in <= general_io_pin_in;
    end
  end

  uadc_sync u_sync_detach (
    .mclk(mclk),
    .srst(srst),
    .din(general_io_pin_in[detach_pin_select]),
    .dout(detach_sync)
  );

  uadc_sync u_sync_vbus (
    .mclk(mclk),
    .srst(srst),
    .din(general_io_pin_in[vbus_pin_select]),
    .dout(vbus_sync)
  );

  assign detached = detach_sync;
  assign bus_powered = ~ctrl[`UADC_CTRL_SELF_POWERED];
  // Bus-powered designs are alive only with VBUS, so sensing is skipped.
  assign vbus_ok = bus_powered | vbus_sync;
  assign attach_ok = ctrl[`UADC_CTRL_READY] & vbus_ok & ~detached;
  assign in_suspend = ctrl[`UADC_CTRL_SUSPEND];

  // ===================================================================
  // Line, pull-up, wake and load control
  always @(posedge mclk) begin : line_ctrl
    integer i;
    if (srst) begin
      general_io_pin_out <= {NUM_PINS{1'b0}};
      general_io_pin_oe <= {NUM_PINS{1'b0}};
      dplus_line_oe <= 1'b0;
      dminus_line_oe <= 1'b0;
      dplus_pullup_int <= 1'b0;
      radio_enable <= 1'b0;
      load_enable <= 1'b0;
      remote_wake_send <= 1'b0;
      endpoint_audio <= 1'b0;
    end else begin
      // Transceiver is only released to the serial engine while attached.
      dplus_line_oe <= attach_ok;
      dminus_line_oe <= attach_ok;
      dplus_pullup_int <= attach_ok & ~ctrl[`UADC_CTRL_PULLUP_EXT];
      for (i = 0; i < NUM_PINS; i = i + 1) begin
        if (ctrl[`UADC_CTRL_PULLUP_EXT] && i == pullup_source_select) begin
          // External resistor: drive high when attached, float otherwise.
          general_io_pin_out[i] <= 1'b1;
          general_io_pin_oe[i] <= attach_ok;
        end else if (i == wake_pin_select) begin
          general_io_pin_out[i] <= detached & ctrl[`UADC_CTRL_WAKE_REQ];
          general_io_pin_oe[i] <= 1'b1;
        end else begin
          general_io_pin_out[i] <= 1'b0;
          general_io_pin_oe[i] <= 1'b0;
        end
      end
      // In-band wake goes out only on an attached, suspended link.
      remote_wake_send <= ctrl[`UADC_CTRL_RWAKE_REQ] & attach_ok & in_suspend;
      radio_enable <= ~(in_suspend & bus_powered);
      load_enable <= ~(in_suspend & bus_powered);
      endpoint_audio <= ctrl[`UADC_CTRL_EP_AUDIO];
    end
  end

  // ===================================================================
  // Avalon-MM slave, one wait cycle per access
  always @* begin
    next_readdata = 32'h00000000;
    case (avs_address)
      `UADC_OFF_CTRL: next_readdata = {25'h0000000, ctrl};
      `UADC_OFF_PINSEL: next_readdata = pinsel;
      `UADC_OFF_POWER: next_readdata = {`UADC_SPEED_KBPS, max_power_setting};
      `UADC_OFF_STATUS: next_readdata = {28'h0000000, attach_ok, vbus_sync, detached,
        raw_in[detach_pin_select]};
      default: next_readdata = 32'h00000000;
    endcase
  end

  always @(posedge mclk) begin
    if (srst) begin
      ctrl <= `UADC_CTRL_RESET;
      pinsel <= `UADC_PINSEL_RESET;
      max_power_setting <= `UADC_MAX_POWER_MA;
      bus_busy <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      avs_waitrequest <= 1'b1;
      bus_busy <= 1'b0;
      // The wake request self-clears once detach state ends it; the in-band wake request does not.
      if (!detached) begin
        ctrl[`UADC_CTRL_WAKE_REQ] <= 1'b0;
      end
      if ((avs_read || avs_write) && !bus_busy) begin
        bus_busy <= 1'b1;
        avs_waitrequest <= 1'b0;
        avs_readdata <= next_readdata;
        if (avs_write) begin
          case (avs_address)
            `UADC_OFF_CTRL: begin
              if (avs_byteenable[0]) begin
                ctrl <= avs_writedata[6:0];
              end
            end
            `UADC_OFF_PINSEL: begin
              if (avs_byteenable[0]) pinsel[7:0] <= avs_writedata[7:0];
              if (avs_byteenable[1]) pinsel[15:8] <= avs_writedata[15:8];
              if (avs_byteenable[2]) pinsel[23:16] <= avs_writedata[23:16];
              if (avs_byteenable[3]) pinsel[31:24] <= avs_writedata[31:24];
            end
            `UADC_OFF_POWER: begin
              if (avs_byteenable[0]) max_power_setting[7:0] <= avs_writedata[7:0];
              if (avs_byteenable[1]) max_power_setting[15:8] <= avs_writedata[15:8];
            end
            default: begin
            end
          endcase
        end
      end
    end
  end
endmodule

// ==== hw/uadc_defs.vh ====
// Constants for the USB attach and detach control block.
`ifndef UADC_DEFS_VH
`define UADC_DEFS_VH
// =====================================================================
// Register byte offsets
`define UADC_OFF_CTRL 4'h0
`define UADC_OFF_PINSEL 4'h4
`define UADC_OFF_POWER 4'h8
`define UADC_OFF_STATUS 4'hc
// =====================================================================
// Control register fields
`define UADC_CTRL_READY 0
`define UADC_CTRL_PULLUP_EXT 1
`define UADC_CTRL_SELF_POWERED 2
`define UADC_CTRL_WAKE_REQ 3
`define UADC_CTRL_SUSPEND 4
`define UADC_CTRL_EP_AUDIO 5
`define UADC_CTRL_RWAKE_REQ 6
// =====================================================================
// Pin select fields
`define UADC_PS_PULLUP_LSB 0
`define UADC_PS_VBUS_LSB 8
`define UADC_PS_DETACH_LSB 16
`define UADC_PS_WAKE_LSB 24
// =====================================================================
// Reset values and the fixed speed field
`define UADC_CTRL_RESET 7'h00
`define UADC_PINSEL_RESET 32'h03020100
`define UADC_MAX_POWER_MA 16'h012c
`define UADC_SPEED_KBPS 16'h2ee0
`endif

// ==== hw/uadc_sync.v ====
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
module uadc_sync (
  input wire mclk,
  input wire srst,
  input wire din,
  output reg dout
);
  reg s1;
  reg s2;
  reg s3;
  // The first stage feeds only the second to contain metastability.
  always @(posedge mclk) begin
    if (srst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule

// ==== verification/uadc_asserts.sv ====
// Concurrent checks on the ports of the USB attach and detach control block.
`timescale 1ns/1ps
`include "uadc_defs.vh"
module uadc_asserts #(
  parameter NUM_PINS = 16,
  parameter SEL_W = 4
) (
  input wire mclk,
  input wire srst,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [NUM_PINS-1:0] general_io_pin_in,
  input wire dplus_line_oe,
  input wire dminus_line_oe,
  input wire dplus_pullup_int,
  input wire remote_wake_send
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_rd_done;
    avs_read && !avs_waitrequest;
  endsequence
  property p_answer;
    s_req |-> ##1 !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("Access not answered next cycle.");
  property p_one_wait;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("Answer held too long.");
  property p_speed;
    s_rd_done and (avs_address == 4'h8) |-> avs_readdata[31:16] == `UADC_SPEED_KBPS;
  endproperty
  a_speed: assert property (p_speed) else $error("Speed field wrong.");
  property p_unmapped;
    s_rd_done and (avs_address[1:0] != 2'h0) |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("Unmapped read not zero.");
  property p_pullup_attached;
    dplus_pullup_int |-> dplus_line_oe;
  endproperty
  a_pullup_attached: assert property (p_pullup_attached) else $error("Pull-up while floated.");
  property p_lines_pair;
    dplus_line_oe == dminus_line_oe;
  endproperty
  a_lines_pair: assert property (p_lines_pair) else $error("Data lines split.");
  property p_no_inband_wake;
    remote_wake_send |-> dplus_line_oe;
  endproperty
  a_no_inband_wake: assert property (p_no_inband_wake) else $error("In-band wake detached.");
  // The pins must have settled through the synchroniser before the lines float.
  property p_sync;
    $fell(dplus_line_oe) |-> $past(general_io_pin_in, 3) == $past(general_io_pin_in, 1);
  endproperty
  a_sync: assert property (p_sync) else $error("Detach acted unsynchronised.");
endmodule
bind uadc_top uadc_asserts #(.NUM_PINS(NUM_PINS), .SEL_W(SEL_W)) i_chk (
  .mclk(mclk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .general_io_pin_in(general_io_pin_in), .dplus_line_oe(dplus_line_oe),
  .dminus_line_oe(dminus_line_oe), .dplus_pullup_int(dplus_pullup_int),
  .remote_wake_send(remote_wake_send));

// ==== verification/uadc_host_model.sv ====
// Far-side model: bus power and detach request levels, pins with pull-downs.
`timescale 1ns/1ps
module uadc_host_model #(
  parameter NUM_PINS = 16
) (
  input wire vbus_on,
  input wire detach_req,
  input wire [3:0] vbus_pin,
  input wire [3:0] detach_pin,
  input wire [NUM_PINS-1:0] pin_out,
  input wire [NUM_PINS-1:0] pin_oe,
  output logic [NUM_PINS-1:0] pin_in
);
  // Undriven pins fall to their pull-down instead of keeping a stale level.
  always_comb begin
    pin_in = pin_out & pin_oe;
    pin_in[vbus_pin] = vbus_on;
    pin_in[detach_pin] = detach_req;
  end
endmodule

// ==== verification/tb_usb_attach_detach_control.sv ====
// Self-checking testbench for the USB attach and detach control block.
`timescale 1ns/1ps
`include "uadc_defs.vh"
module tb_usb_attach_detach_control;
  logic mclk = 1'h0, srst = 1'h1, rd = 1'h0, wr = 1'h0, vbus = 1'h0, det = 1'h0;
  logic [3:0] adr = 4'h0, vpin = 4'h1, dpin = 4'h2, be = 4'hf;
  logic [31:0] wdat = 32'h0, q;
  wire [31:0] rdat;
  wire [15:0] pin_in, pin_out, pin_oe;
  wire wtreq, dp_oe, dn_oe, pu, radio, load, rwake, audio;
  int miscompares = 0, checks_done = 0;
  always #5 mclk = ~mclk;
  uadc_top i_dut (.mclk(mclk), .srst(srst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wtreq),
    .general_io_pin_in(pin_in), .general_io_pin_out(pin_out), .general_io_pin_oe(pin_oe),
    .dplus_line_oe(dp_oe), .dminus_line_oe(dn_oe), .dplus_pullup_int(pu), .radio_enable(radio),
    .load_enable(load), .remote_wake_send(rwake), .endpoint_audio(audio));
  uadc_host_model i_host (.vbus_on(vbus), .detach_req(det), .vbus_pin(vpin),
    .detach_pin(dpin), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
  task print_verdict;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // The request is held until waitrequest is seen low, then released for one edge.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge mclk);
      n++;
    end while (wtreq !== 1'h0 && n < 50);
    q = rdat;
    wr <= 1'h0;
    rd <= 1'h0;
    @(posedge mclk);
    if (n >= 50) begin
      miscompares++;
      print_verdict;
    end
  endtask
  task t_regs;
    bus(1'h0, 4'h8, 32'h0);
    chk(q, {`UADC_SPEED_KBPS, `UADC_MAX_POWER_MA});
    // Only lane 0 is enabled, so the upper byte of the power setting must survive.
    be <= 4'h1;
    bus(1'h1, 4'h8, 32'hffff00fa);
    be <= 4'hf;
    bus(1'h0, 4'h8, 32'h0);
    chk(q, {`UADC_SPEED_KBPS, 16'h01fa});
    bus(1'h0, 4'h4, 32'h0);
    chk(q, `UADC_PINSEL_RESET);
    bus(1'h0, 4'h2, 32'h0);
    chk(q, 32'h0);
    chk(pu, 1'h0);
  endtask
  task t_attach;
    bus(1'h1, 4'h0, 32'h1);
    repeat (3) @(posedge mclk);
    chk({dp_oe, dn_oe, pu}, 3'h7);
    bus(1'h1, 4'h0, 32'h3);
    repeat (3) @(posedge mclk);
    chk({pu, pin_out[0], pin_oe[0]}, 3'h3);
    bus(1'h1, 4'h0, 32'h7);
    repeat (3) @(posedge mclk);
    chk(pin_out[0] & pin_oe[0], 1'h0);
    bus(1'h1, 4'h4, 32'h07060500);
    vpin <= 4'h5;
    dpin <= 4'h6;
    vbus <= 1'h1;
    repeat (8) @(posedge mclk);
    chk(pin_out[0] & pin_oe[0], 1'h1);
  endtask
  // Wake request only sticks once detached, so it is written after the lines float.
  task t_detach;
    bus(1'h1, 4'h0, 32'h1);
    det <= 1'h1;
    repeat (8) @(posedge mclk);
    chk({dp_oe, dn_oe, pu}, 3'h0);
    bus(1'h0, 4'hc, 32'h0);
    chk(q, 32'h7);
    bus(1'h1, 4'h0, 32'h59);
    repeat (3) @(posedge mclk);
    chk({pin_out[7] & pin_oe[7], rwake}, 2'h2);
    det <= 1'h0;
    repeat (8) @(posedge mclk);
    chk({dp_oe, pu, pin_out[7] & pin_oe[7], rwake}, 4'hd);
    chk({radio, load}, 2'h0);
    bus(1'h1, 4'h0, 32'h21);
    repeat (3) @(posedge mclk);
    chk({audio, radio, load, rwake}, 4'he);
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    srst <= 1'h0;
    t_regs;
    t_attach;
    t_detach;
    print_verdict;
  end
endmodule
